// ==== rtl/sbc_mode_wd.sv ====
`timescale 1ns/1ps
module sbc_mode_wd #(
  parameter int CYC_PER_MS     = sbc_wd_pkg::CYC_PER_MS,
  parameter int RESET_HOLD_CYC = sbc_wd_pkg::RESET_HOLD_CYC
) (
  input  wire logic                 I_CLK,            // device clock
  input  wire logic                 I_RST_N,          // power-on reset, sync
  input  wire sbc_wd_pkg::pins_t    I_PINS,           // serial pins and warning
  input  wire sbc_wd_pkg::events_t  I_EVENTS,         // reset and wake pulses
  input  wire logic                 I_RXD_LOW,        // pending wake-up level
  input  wire logic                 I_FORCED_NORMAL,  // forced_normal_enable
  input  wire logic                 I_SW_DEBUG,       // software_debug_enable
  input  wire logic                 I_SPI_FAIL_EN,    // failure event enable
  input  wire logic                 I_SLEEP_BLOCKED,  // sleep would be illegal
  output logic                      O_SDO,            // serial data out
  output logic                      O_SDO_OE,         // serial out enable
  output sbc_wd_pkg::op_mode_t      O_OP_MODE,        // operating mode
  output logic                      O_RESET_OUT_N,    // reset_out_n level
  output logic                      O_SPI_FAIL,       // failure event pulse
  output logic                      O_WD_FAIL_FLAG,   // watchdog_fail_flag
  output sbc_wd_pkg::wd_run_t       O_WD_RUN          // running watchdog mode
);

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic nwp_ok(input logic [3:0] watchdog_period_select);
    logic ok;
    ok = 1'b0;
    for (int i = 0; i < sbc_wd_pkg::NWP_NUM; i++)
    begin
      if (watchdog_period_select == sbc_wd_pkg::NWP_CODES[i]) ok = 1'b1;
    end
    return ok;
  endfunction : nwp_ok

  function automatic logic [31:0] period_cyc(input logic [3:0] watchdog_period_select);
    logic [31:0] p;
    p = 32'h1;
    for (int i = 0; i < sbc_wd_pkg::NWP_NUM; i++)
    begin
      if (watchdog_period_select == sbc_wd_pkg::NWP_CODES[i]) p = 32'(sbc_wd_pkg::NWP_MS[i] * CYC_PER_MS);
    end
    return p;
  endfunction : period_cyc

  function automatic sbc_wd_pkg::wd_run_t run_mode(input logic [2:0] watchdog_mode_select,
                                                   input sbc_wd_pkg::op_mode_t m,
                                                   input logic fnm, input logic sdm,
                                                   input logic rxd_low);
    sbc_wd_pkg::wd_run_t r;
    r = sbc_wd_pkg::WD_OFF;
    if (!fnm && m != sbc_wd_pkg::ST_RESET)
    begin
      if (watchdog_mode_select == sbc_wd_pkg::WMC_WINDOW)
        r = (m == sbc_wd_pkg::ST_NORMAL) ? sbc_wd_pkg::WD_WINDOW : sbc_wd_pkg::WD_TIMEOUT;
      else if (watchdog_mode_select == sbc_wd_pkg::WMC_TIMEOUT)
        r = sbc_wd_pkg::WD_TIMEOUT;
      else if (!sdm && (m == sbc_wd_pkg::ST_NORMAL
                        || (m == sbc_wd_pkg::ST_STANDBY && rxd_low)))
        r = sbc_wd_pkg::WD_TIMEOUT;
    end
    return r;
  endfunction : run_mode

  //////////////////////////////////////////////////////////////////////////////
  sbc_wd_pkg::pins_t    sync1_q, sync2_q;
  logic                 sck_prev_q, csn_prev_q;
  logic [4:0]           bit_cnt_q;
  logic [15:0]          rx_q;
  logic [7:0]           tx_q;
  logic                 sdo_q, oe_q, fail_q, reset_out_n_q, nms_q, wdf_q, first_q;
  logic [4:0]           rss_q;
  logic [2:0]           wmc_q;
  logic [3:0]           nwp_q;
  logic [31:0]          wd_cnt_q;
  logic [15:0]          hold_q;
  sbc_wd_pkg::op_mode_t mode_q, mode_d;
  sbc_wd_pkg::wd_run_t  run_q, run;

  // serial pins and warning pass two flops first
  always_ff @(posedge I_CLK)
  begin
    sync1_q <= I_PINS;
    sync2_q <= sync1_q;
    sck_prev_q <= sync2_q.sck;
    csn_prev_q <= sync2_q.csn_n;
  end

  //////////////////////////////////////////////////////////////////////////////
  wire        sck_rise = sync2_q.sck & ~sck_prev_q;
  wire        sck_fall = ~sync2_q.sck & sck_prev_q;
  wire        csn_end  = sync2_q.csn_n & ~csn_prev_q;
  wire        spi_on   = (mode_q == sbc_wd_pkg::ST_STANDBY) | (mode_q == sbc_wd_pkg::ST_NORMAL);
  wire        len_ok   = bit_cnt_q == 5'(sbc_wd_pkg::SPI_FRAME_BITS);
  wire        wr       = csn_end & spi_on & len_ok & ~rx_q[sbc_wd_pkg::SPI_RO_BIT];
  wire        len_bad  = csn_end & spi_on & ~len_ok & (bit_cnt_q != 5'h00);
  wire [6:0]  addr     = rx_q[15:9];
  wire [7:0]  wdata    = rx_q[7:0];
  wire [6:0]  rd_addr  = rx_q[6:0];
  wire [2:0]  new_wmc  = wdata[7:5];
  wire [3:0]  new_nwp  = wdata[3:0];
  wire        wmc_ok   = (new_wmc == sbc_wd_pkg::WMC_AUTO) | (new_wmc == sbc_wd_pkg::WMC_TIMEOUT)
                         | (new_wmc == sbc_wd_pkg::WMC_WINDOW);
  wire        code_ok  = wmc_ok & nwp_ok(new_nwp);
  wire        wd_wr    = wr & (addr == sbc_wd_pkg::ADDR_WDCTL);
  wire        wd_bad   = wd_wr & ~code_ok;
  wire        wd_ill   = wd_wr & code_ok & (mode_q == sbc_wd_pkg::ST_NORMAL)
                         & (new_wmc != wmc_q);
  wire        wd_trig  = wd_wr & code_ok & ~wd_ill;
  wire        mode_wr  = wr & (addr == sbc_wd_pkg::ADDR_MODE);
  wire [2:0]  mc       = wdata[2:0];
  wire        ill_slp  = mode_wr & (mc == sbc_wd_pkg::MC_SLEEP) & I_SLEEP_BLOCKED;

  wire [7:0]  stat_word = {1'b0, sync2_q.otw, nms_q, rss_q};
  wire [2:0]  mc_now    = (mode_q == sbc_wd_pkg::ST_NORMAL) ? sbc_wd_pkg::MC_NORMAL :
                          (mode_q == sbc_wd_pkg::ST_SLEEP)  ? sbc_wd_pkg::MC_SLEEP :
                                                              sbc_wd_pkg::MC_STANDBY;
  wire [7:0]  rd_word   = (rd_addr == sbc_wd_pkg::ADDR_STAT)  ? stat_word :
                          (rd_addr == sbc_wd_pkg::ADDR_MODE)  ? {5'h00, mc_now} :
                          (rd_addr == sbc_wd_pkg::ADDR_WDCTL) ? {wmc_q, 1'b0, nwp_q} :
                                                                8'h00;

  //////////////////////////////////////////////////////////////////////////////
  wire [31:0] period   = period_cyc(nwp_q);
  wire        in_sleep = mode_q == sbc_wd_pkg::ST_SLEEP;
  assign run = run_mode(wmc_q, mode_q, I_FORCED_NORMAL, I_SW_DEBUG, I_RXD_LOW);
  wire        ovf      = (run != sbc_wd_pkg::WD_OFF) & (wd_cnt_q >= period - 32'h1);
  wire        early    = wd_trig & (run == sbc_wd_pkg::WD_WINDOW)
                         & (wd_cnt_q < (period >> 1));
  wire        ovf_slp  = ovf & in_sleep;
  wire        ovf_bad  = ovf & ~in_sleep & ((run == sbc_wd_pkg::WD_WINDOW) | wdf_q);
  wire        ovf_1st  = ovf & ~in_sleep & ~ovf_bad;
  wire        restart  = (run == sbc_wd_pkg::WD_OFF) | wd_trig | (run != run_q) | ovf_1st;

  wire [4:0]  rst_code =
    I_EVENTS.v1_undervoltage           ? sbc_wd_pkg::RSS_V1_UV :
    I_EVENTS.ext_reset                 ? sbc_wd_pkg::RSS_EXT_RESET :
    I_EVENTS.overtemp_exit             ? sbc_wd_pkg::RSS_OVERTEMP :
    wd_ill                             ? sbc_wd_pkg::RSS_WMC_ILLEGAL :
    early                              ? sbc_wd_pkg::RSS_WD_EARLY :
    ovf_bad                            ? sbc_wd_pkg::RSS_WD_OVERFLOW :
    ovf_slp                            ? sbc_wd_pkg::RSS_WD_SLEEP :
    (in_sleep & I_EVENTS.can_wake)     ? sbc_wd_pkg::RSS_CAN_WAKE :
    (in_sleep & I_EVENTS.local_wake)   ? sbc_wd_pkg::RSS_LOCAL_WAKE :
    (in_sleep & I_EVENTS.diag_wake)    ? sbc_wd_pkg::RSS_DIAG_WAKE :
    (in_sleep & I_EVENTS.frame_err_wake) ? sbc_wd_pkg::RSS_FRAME_ERR :
                                         sbc_wd_pkg::RSS_ILL_SLEEP;
  wire        wake_ev  = in_sleep & (I_EVENTS.can_wake | I_EVENTS.local_wake
                         | I_EVENTS.diag_wake | I_EVENTS.frame_err_wake);
  wire        rst_req  = (mode_q != sbc_wd_pkg::ST_RESET)
                         & (I_EVENTS.v1_undervoltage | I_EVENTS.ext_reset
                            | I_EVENTS.overtemp_exit | wd_ill | early | ovf_bad
                            | ovf_slp | wake_ev | ill_slp);

  always_comb
  begin
    mode_d = mode_q;
    case (mode_q)
      sbc_wd_pkg::ST_RESET:
      begin
        if (hold_q >= 16'(RESET_HOLD_CYC - 1)) mode_d = sbc_wd_pkg::ST_STANDBY;
      end
      default:
      begin
        if (rst_req) mode_d = sbc_wd_pkg::ST_RESET;
        else if (mode_wr && mc == sbc_wd_pkg::MC_SLEEP) mode_d = sbc_wd_pkg::ST_SLEEP;
        else if (mode_wr && mc == sbc_wd_pkg::MC_STANDBY) mode_d = sbc_wd_pkg::ST_STANDBY;
        else if (mode_wr && mc == sbc_wd_pkg::MC_NORMAL) mode_d = sbc_wd_pkg::ST_NORMAL;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // serial shifter: sample on rising sck, drive on falling sck
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N || sync2_q.csn_n)
    begin
      bit_cnt_q <= (!I_RST_N) ? 5'h00 : ((csn_end) ? bit_cnt_q : 5'h00);
      tx_q      <= 8'h00;
      sdo_q     <= 1'b0;
      if (!I_RST_N) rx_q <= 16'h0000;
    end
    else
    begin
      if (sck_rise)
      begin
        rx_q <= {rx_q[14:0], sync2_q.sdi};
        if (bit_cnt_q != 5'h1F) bit_cnt_q <= bit_cnt_q + 5'h01;
        if (bit_cnt_q == 5'h07) tx_q <= rd_word;
      end
      if (sck_fall)
      begin
        sdo_q <= tx_q[7];
        tx_q  <= {tx_q[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      oe_q   <= 1'b0;
      fail_q <= 1'b0;
      reset_out_n_q <= 1'b0;
    end
    else
    begin
      oe_q   <= ~sync2_q.csn_n & spi_on;
      fail_q <= I_SPI_FAIL_EN & (wd_bad | len_bad);
      reset_out_n_q <= (mode_d == sbc_wd_pkg::ST_STANDBY) | (mode_d == sbc_wd_pkg::ST_NORMAL);
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      mode_q <= sbc_wd_pkg::ST_RESET;
      hold_q <= 16'h0000;
      rss_q  <= sbc_wd_pkg::RSS_POWER_ON;
      nms_q  <= 1'b1;
    end
    else
    begin
      mode_q <= mode_d;
      hold_q <= (mode_q == sbc_wd_pkg::ST_RESET) ? hold_q + 16'h0001 : 16'h0000;
      if (rst_req) rss_q <= rst_code;
      if (mode_q == sbc_wd_pkg::ST_NORMAL) nms_q <= 1'b0;
    end
  end

  // watchdog configuration; default mode follows debug level after release
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      wmc_q   <= sbc_wd_pkg::WMC_TIMEOUT;
      nwp_q   <= sbc_wd_pkg::NWP_DEFAULT;
      first_q <= 1'b1;
    end
    else
    begin
      first_q <= 1'b0;
      if (first_q) wmc_q <= I_SW_DEBUG ? sbc_wd_pkg::WMC_AUTO : sbc_wd_pkg::WMC_TIMEOUT;
      else if (wd_trig)
      begin
        wmc_q <= new_wmc;
        nwp_q <= new_nwp;
      end
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      wd_cnt_q <= 32'h0;
      run_q    <= sbc_wd_pkg::WD_OFF;
      wdf_q    <= 1'b0;
    end
    else
    begin
      run_q    <= run;
      wd_cnt_q <= restart ? 32'h0 : wd_cnt_q + 32'h1;
      if (ovf_1st) wdf_q <= 1'b1;
      else if (mode_q == sbc_wd_pkg::ST_RESET) wdf_q <= 1'b0;
    end
  end

  assign O_SDO          = sdo_q;
  assign O_SDO_OE       = oe_q;
  assign O_OP_MODE      = mode_q;
  assign O_RESET_OUT_N  = reset_out_n_q;
  assign O_SPI_FAIL     = fail_q;
  assign O_WD_FAIL_FLAG = wdf_q;
  assign O_WD_RUN       = run_q;

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);

  property p_mode_normal;
    mode_wr && mc == sbc_wd_pkg::MC_NORMAL && !rst_req |=> mode_q == sbc_wd_pkg::ST_NORMAL;
  endproperty
  a_mode_normal: assert property (p_mode_normal) else $error("normal request not taken");

  property p_nms_clear;
    mode_q == sbc_wd_pkg::ST_NORMAL |=> !nms_q ##1 !nms_q;
  endproperty
  a_nms_clear: assert property (p_nms_clear) else $error("normal flag not cleared");

  property p_illegal_wmc;
    wd_ill |=> mode_q == sbc_wd_pkg::ST_RESET && rss_q == sbc_wd_pkg::RSS_WMC_ILLEGAL;
  endproperty
  a_illegal_wmc: assert property (p_illegal_wmc) else $error("illegal mode change missed");

  property p_early;
    early |=> rss_q == sbc_wd_pkg::RSS_WD_EARLY && !O_RESET_OUT_N;
  endproperty
  a_early: assert property (p_early) else $error("early trigger not reset");

  property p_sleep_ovf;
    ovf_slp |=> mode_q == sbc_wd_pkg::ST_RESET && rss_q == sbc_wd_pkg::RSS_WD_SLEEP;
  endproperty
  a_sleep_ovf: assert property (p_sleep_ovf) else $error("sleep overflow not reported");

  property p_trig_restart;
    wd_trig && run == sbc_wd_pkg::WD_TIMEOUT |=> wd_cnt_q == 32'h0 ##1 wd_cnt_q <= 32'h1;
  endproperty
  a_trig_restart: assert property (p_trig_restart) else $error("trigger did not restart");

  property p_bad_code;
    wd_bad |=> $stable(wmc_q) && $stable(nwp_q) && O_SPI_FAIL == $past(I_SPI_FAIL_EN);
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("invalid code not rejected");

  property p_window_standby;
    wmc_q == sbc_wd_pkg::WMC_WINDOW && mode_q == sbc_wd_pkg::ST_STANDBY && !I_FORCED_NORMAL
      |-> run == sbc_wd_pkg::WD_TIMEOUT;
  endproperty
  a_window_standby: assert property (p_window_standby) else $error("window ran early");

  property p_forced_off;
    I_FORCED_NORMAL [*2] |-> wd_cnt_q == 32'h0 && O_WD_RUN == sbc_wd_pkg::WD_OFF;
  endproperty
  a_forced_off: assert property (p_forced_off) else $error("watchdog ran in forced normal");

endmodule : sbc_mode_wd

// ==== rtl/sbc_wd_pkg.sv ====
//////////////////////////////////////////////////////////////////////////////
// Contract
// - mode codes: Sleep 001, Standby 100, Normal 111
// - mode register at 0x01, only mode field writable
// - bit 6 shows live overtemperature warning level
// - bit 5 set from power-up until Normal entered
// - reset cause: power-on, CAN wake, local wake
// - reset cause: sleep overflow, early trigger, overflow
// - reset cause: external reset, overtemp exit, undervoltage
// - reset cause: diagnostic wake, illegal sleep, frame error
// - window mode: trigger only inside window, restarts timer
// - timeout mode: any trigger restarts running timer
// - timeout mode keeps running in Sleep
// - window code runs timeout until Normal entered
// - mode change in Normal forces reset, cause 10000
// - eight periods 8 to 4096 ms, default 128
// - valid watchdog control write is a trigger
// - new mode or period valid from that write
// - autonomous: timeout in Normal, off Sleep, debug off
// - autonomous Standby: timeout only while receive line low
// - invalid code abandons write, flags serial failure
// - redundant watchdog codes, single error never valid
// - forced normal disables watchdog everywhere
//////////////////////////////////////////////////////////////////////////////
package sbc_wd_pkg;

  localparam logic [6:0] ADDR_WDCTL = 7'h00;
  localparam logic [6:0] ADDR_MODE  = 7'h01;
  localparam logic [6:0] ADDR_STAT  = 7'h03;

  localparam logic [2:0] MC_SLEEP   = 3'h1;
  localparam logic [2:0] MC_STANDBY = 3'h4;
  localparam logic [2:0] MC_NORMAL  = 3'h7;

  localparam logic [2:0] WMC_AUTO    = 3'h1;
  localparam logic [2:0] WMC_TIMEOUT = 3'h2;
  localparam logic [2:0] WMC_WINDOW  = 3'h4;
  localparam logic [3:0] NWP_DEFAULT = 4'h4;

  localparam int         NWP_NUM = 8;
  localparam logic [3:0] NWP_CODES [NWP_NUM] = '{4'h8, 4'h1, 4'h2, 4'hB,
                                                  4'h4, 4'hD, 4'hE, 4'h7};
  localparam int         NWP_MS    [NWP_NUM] = '{8, 16, 32, 64, 128, 256, 1024, 4096};

  localparam logic [4:0] RSS_POWER_ON    = 5'h00;
  localparam logic [4:0] RSS_CAN_WAKE    = 5'h01;
  localparam logic [4:0] RSS_LOCAL_WAKE  = 5'h04;
  localparam logic [4:0] RSS_WD_SLEEP    = 5'h0C;
  localparam logic [4:0] RSS_DIAG_WAKE   = 5'h0D;
  localparam logic [4:0] RSS_WD_EARLY    = 5'h0E;
  localparam logic [4:0] RSS_WD_OVERFLOW = 5'h0F;
  localparam logic [4:0] RSS_WMC_ILLEGAL = 5'h10;
  localparam logic [4:0] RSS_EXT_RESET   = 5'h11;
  localparam logic [4:0] RSS_OVERTEMP    = 5'h12;
  localparam logic [4:0] RSS_V1_UV       = 5'h13;
  localparam logic [4:0] RSS_ILL_SLEEP   = 5'h14;
  localparam logic [4:0] RSS_FRAME_ERR   = 5'h16;

  localparam int         SPI_FRAME_BITS = 16;
  localparam int         SPI_RO_BIT     = 8;
  localparam int         OTW_BIT        = 6;
  localparam int         NMS_BIT        = 5;

  localparam int CLK_PERIOD_NS  = 100;
  localparam int NS_PER_MS      = 1000000;
  localparam int CYC_PER_MS     = NS_PER_MS / CLK_PERIOD_NS;
  localparam int RESET_HOLD_NS  = 20000;
  localparam int RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    ST_STANDBY = 4'b0001,
    ST_NORMAL  = 4'b0010,
    ST_SLEEP   = 4'b0100,
    ST_RESET   = 4'b1000
  } op_mode_t;

  typedef enum logic [1:0] {
    WD_OFF     = 2'h0,
    WD_TIMEOUT = 2'h1,
    WD_WINDOW  = 2'h2
  } wd_run_t;

  typedef struct packed {
    logic can_wake;
    logic local_wake;
    logic diag_wake;
    logic frame_err_wake;
    logic ext_reset;
    logic overtemp_exit;
    logic v1_undervoltage;
  } events_t;

  typedef struct packed {
    logic otw;
    logic csn_n;
    logic sdi;
    logic sck;
  } pins_t;

endpackage : sbc_wd_pkg

// ==== verification/spi_host_model.sv ====
`timescale 1ns/1ps
module spi_host_model (
  input  wire logic i_clk,     // device clock
  input  wire logic i_sdo,     // serial data from device
  input  wire logic i_sdo_oe,  // device drives serial data
  output logic      o_csn_n,   // frame select, active low
  output logic      o_sck,     // serial clock, idles low
  output logic      o_sdi      // serial data to device
);
  logic last_bit;

  initial
  begin
    o_csn_n  = 1'b1;
    o_sck    = 1'b0;
    o_sdi    = 1'b0;
    last_bit = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tick

  // one frame: address, read flag, data, msb first; sck period is 8 device clocks
  task automatic xfer(input logic [15:0] frame, input int nbits, output logic [7:0] rd);
    logic line;
    rd = 8'h00;
    tick(1);
    o_csn_n = 1'b0;
    for (int i = 0; i < nbits; i++)
    begin
      tick(2);
      o_sdi = frame[15 - i];
      tick(2);
      o_sck = 1'b1;
      // a released line carries no old value
      line     = i_sdo_oe ? i_sdo : ~last_bit;
      last_bit = line;
      if (i >= 8)
        rd = {rd[6:0], line};
      tick(4);
      o_sck = 1'b0;
    end
    tick(4);
    o_csn_n = 1'b1;
    tick(8);
  endtask : xfer
endmodule : spi_host_model

// ==== verification/sbc_mode_and_watchdog_control_tb.sv ====
`timescale 1ns/1ps
module sbc_mode_and_watchdog_control_tb;
  typedef struct packed {logic wr; logic [6:0] a; logic [7:0] d;} acc_t;
  typedef struct packed {logic [2:0] idx; logic slp; logic [4:0] cause;} evt_t;

  logic                     clk = 1'b0;
  logic                     rst_n = 1'b0;
  logic                     otw = 1'b0;
  logic                     csn_n, sck, sdi, sdo, sdo_oe, spi_fail, wd_fail, rst_out_n;
  sbc_wd_pkg::events_t      events = '0;
  logic                     rxd_low = 1'b0, fnm = 1'b0, sw_dbg = 1'b0, blk = 1'b0;
  logic                     fail_en = 1'b1;
  sbc_wd_pkg::op_mode_t     op_mode;
  sbc_wd_pkg::wd_run_t      wd_run;
  int                       fail_count = 0, compares = 0, spi_fails = 0;
  logic [7:0]               rd;

  always #50 clk = ~clk;

  sbc_mode_wd #(.CYC_PER_MS(10), .RESET_HOLD_CYC(8)) uut (
    .I_CLK(clk), .I_RST_N(rst_n),
    .I_PINS({otw, csn_n, sdi, sck}), .I_EVENTS(events),
    .I_RXD_LOW(rxd_low), .I_FORCED_NORMAL(fnm), .I_SW_DEBUG(sw_dbg),
    .I_SPI_FAIL_EN(fail_en), .I_SLEEP_BLOCKED(blk), .O_SDO(sdo), .O_SDO_OE(sdo_oe),
    .O_OP_MODE(op_mode), .O_RESET_OUT_N(rst_out_n), .O_SPI_FAIL(spi_fail),
    .O_WD_FAIL_FLAG(wd_fail), .O_WD_RUN(wd_run));

  spi_host_model host (.i_clk(clk), .i_sdo(sdo), .i_sdo_oe(sdo_oe),
    .o_csn_n(csn_n), .o_sck(sck), .o_sdi(sdi));

  always @(posedge clk)
    if (spi_fail === 1'b1)
      spi_fails <= spi_fails + 1;

  acc_t rows [19] = '{
    '{1'b0, 7'h03, 8'h20},
    '{1'b0, 7'h00, 8'h44},
    '{1'b0, 7'h01, 8'h04},
    '{1'b1, 7'h01, 8'h02},
    '{1'b0, 7'h01, 8'h04},
    '{1'b1, 7'h03, 8'hFF},
    '{1'b0, 7'h03, 8'h20},
    '{1'b0, 7'h02, 8'h00},
    '{1'b1, 7'h00, 8'h47},
    '{1'b0, 7'h00, 8'h47},
    '{1'b1, 7'h00, 8'h68},
    '{1'b0, 7'h00, 8'h47},
    '{1'b1, 7'h00, 8'h39},
    '{1'b0, 7'h00, 8'h47},
    '{1'b1, 7'h01, 8'hFF},
    '{1'b0, 7'h01, 8'h07},
    '{1'b0, 7'h03, 8'h00},
    '{1'b1, 7'h01, 8'h04},
    '{1'b0, 7'h01, 8'h04}};

  evt_t evts [7] = '{
    '{3'd6, 1'b1, 5'h01},
    '{3'd5, 1'b1, 5'h04},
    '{3'd4, 1'b1, 5'h0D},
    '{3'd3, 1'b1, 5'h16},
    '{3'd2, 1'b0, 5'h11},
    '{3'd1, 1'b0, 5'h12},
    '{3'd0, 1'b0, 5'h13}};

  task automatic complete_run;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.xfer({a, 1'b0, d}, 16, rd);
  endtask : wr

  task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
    host.xfer({a, 1'b1, 8'h00}, 16, rd);
    chk($sformatf("register %h", a), exp, rd);
  endtask : rdchk

  task automatic wait_mode(input sbc_wd_pkg::op_mode_t m, input int lim);
    for (int n = 0; n < lim && op_mode !== m; n++)
      tick(1);
    chk("op mode", {4'h0, m}, {4'h0, op_mode});
  endtask : wait_mode

  task automatic run_is(input sbc_wd_pkg::wd_run_t r);
    tick(3);
    chk("watchdog run", {6'h00, r}, {6'h00, wd_run});
  endtask : run_is

  initial
  begin
    repeat (60000) @(posedge clk);
    fail_count++;
    complete_run();
  end

  initial
  begin
    tick(8);
    chk("reset out low", 8'h00, {7'h00, rst_out_n});
    rst_n = 1'b1;
    wait_mode(sbc_wd_pkg::ST_STANDBY, 100);
    foreach (rows[i])
      if (rows[i].wr)
        wr(rows[i].a, rows[i].d);
      else
        rdchk(rows[i].a, rows[i].d);
    // a short frame is refused with a failure pulse; a disabled event stays quiet
    host.xfer({7'h01, 1'b0, 8'h07}, 12, rd);
    rdchk(7'h01, 8'h04);
    fail_en = 1'b0;
    wr(7'h00, 8'h68);
    fail_en = 1'b1;
    rdchk(7'h00, 8'h47);
    chk("serial failures", 8'h03, 8'(spi_fails));
    otw = 1'b1;
    rdchk(7'h03, 8'h40);
    otw = 1'b0;
    rdchk(7'h03, 8'h00);
    wr(7'h00, 8'h24);
    run_is(sbc_wd_pkg::WD_OFF);
    rxd_low = 1'b1;
    run_is(sbc_wd_pkg::WD_TIMEOUT);
    sw_dbg = 1'b1;
    run_is(sbc_wd_pkg::WD_OFF);
    sw_dbg = 1'b0;
    rxd_low = 1'b0;
    wr(7'h01, 8'h07);
    run_is(sbc_wd_pkg::WD_TIMEOUT);
    wr(7'h01, 8'h04);
    wr(7'h00, 8'h44);
    fnm = 1'b1;
    run_is(sbc_wd_pkg::WD_OFF);
    fnm = 1'b0;
    // window code waits for normal mode, then an early trigger resets
    wr(7'h00, 8'h84);
    run_is(sbc_wd_pkg::WD_TIMEOUT);
    wr(7'h01, 8'h07);
    run_is(sbc_wd_pkg::WD_WINDOW);
    wr(7'h00, 8'h84);
    wait_mode(sbc_wd_pkg::ST_RESET, 20);
    chk("reset out low", 8'h00, {7'h00, rst_out_n});
    wait_mode(sbc_wd_pkg::ST_STANDBY, 50);
    rdchk(7'h03, 8'h0E);
    wr(7'h00, 8'h44);
    wr(7'h01, 8'h07);
    wr(7'h00, 8'h84);
    wait_mode(sbc_wd_pkg::ST_RESET, 20);
    wait_mode(sbc_wd_pkg::ST_STANDBY, 50);
    rdchk(7'h03, 8'h10);
    wr(7'h00, 8'h44);
    foreach (evts[i])
    begin
      if (evts[i].slp)
        wr(7'h01, 8'h01);
      events = sbc_wd_pkg::events_t'(7'h01 << evts[i].idx);
      tick(1);
      events = '0;
      wait_mode(sbc_wd_pkg::ST_RESET, 20);
      wait_mode(sbc_wd_pkg::ST_STANDBY, 50);
      rdchk(7'h03, {3'b000, evts[i].cause});
    end
    blk = 1'b1;
    wr(7'h01, 8'h01);
    wait_mode(sbc_wd_pkg::ST_RESET, 20);
    blk = 1'b0;
    wait_mode(sbc_wd_pkg::ST_STANDBY, 50);
    rdchk(7'h03, 8'h14);
    // 32 ms period: 320 cycles at the shortened rate
    wr(7'h00, 8'h42);
    wr(7'h01, 8'h01);
    wait_mode(sbc_wd_pkg::ST_SLEEP, 5);
    wait_mode(sbc_wd_pkg::ST_RESET, 400);
    wait_mode(sbc_wd_pkg::ST_STANDBY, 50);
    rdchk(7'h03, 8'h0C);
    wr(7'h00, 8'h42);
    tick(250);
    chk("fail flag early", 8'h00, {7'h00, wd_fail});
    for (int n = 0; n < 100 && wd_fail !== 1'b1; n++)
      tick(1);
    chk("fail flag", 8'h01, {7'h00, wd_fail});
    wait_mode(sbc_wd_pkg::ST_RESET, 400);
    tick(2);
    chk("fail flag cleared", 8'h00, {7'h00, wd_fail});
    wait_mode(sbc_wd_pkg::ST_STANDBY, 50);
    rdchk(7'h03, 8'h0F);
    // power-on reset in mid-run restores flag, cause and defaults
    rst_n = 1'b0;
    tick(8);
    chk("reset out low", 8'h00, {7'h00, rst_out_n});
    rst_n = 1'b1;
    wait_mode(sbc_wd_pkg::ST_STANDBY, 100);
    rdchk(7'h03, 8'h20);
    rdchk(7'h00, 8'h44);
    complete_run();
  end
endmodule : sbc_mode_and_watchdog_control_tb
